// file: design/cic_cfg.svh
/*
 Constants of the cascaded interrupt controller: port addresses, field
 positions and reset values. Assumes an 8-bit I/O address bus.
*/
`ifndef CIC_CFG_SVH
`define CIC_CFG_SVH

`define CIC_PRI_EVEN 8'h20
`define CIC_PRI_ODD 8'h21
`define CIC_SEC_EVEN 8'hA0
`define CIC_SEC_ODD 8'hA1

`define CIC_INIT_BIT 4
`define CIC_OPERATIONAL_WORD_THREE_BIT 3
`define CIC_LEVEL_BIT 3
`define CIC_AEOI_BIT 1
`define CIC_ESMM_BIT 6
`define CIC_SMM_BIT 5
`define CIC_POLL_BIT 2
`define CIC_RR_BIT 1
`define CIC_RIS_BIT 0

`define CIC_SLAVE_ID_RST 3'h7
`define CIC_LOWEST_RST 3'h7
`define CIC_MASK_RST 8'h00
`define CIC_CASCADE_CH 3'h2
`define CIC_SPURIOUS_CH 3'h7
`define CIC_UNMAPPED_DATA 8'h00

`endif

// file: design/cic_pkg.sv
/*
 Types of the cascaded interrupt controller.
 Assumes cic_cfg.svh is available on the include path.
*/
package cic_pkg;

	typedef enum logic [3:0] {
		CIC_RUN = 4'h1,
		CIC_W2 = 4'h2,
		CIC_W3 = 4'h4,
		CIC_W4 = 4'h8
	} cic_phase_type;

	typedef enum logic [2:0] {
		CIC_ROT_CLR = 3'h0,
		CIC_EOI_NS = 3'h1,
		CIC_NOP = 3'h2,
		CIC_EOI_SP = 3'h3,
		CIC_ROT_SET = 3'h4,
		CIC_ROT_EOI_NS = 3'h5,
		CIC_SET_PRIO = 3'h6,
		CIC_ROT_EOI_SP = 3'h7
	} cic_operational_word_two_type;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cic_io_req_type;

	typedef struct packed {
		cic_phase_type phase;
		logic [7:0] request_register;
		logic [7:0] in_service_register;
		logic [7:0] mask_register;
		logic [7:0] req_prev;
		logic [4:0] vec_base;
		logic [2:0] slave_id;
		logic [2:0] lowest;
		logic [2:0] cur;
		logic level_mode;
		logic aeoi;
		logic rot_auto;
		logic smm;
		logic sel_isr;
		logic poll_pend;
	} cic_ctrl_state_type;

	typedef struct packed {
		logic [15:0] pin_s1;
		logic [15:0] pin_s2;
		logic [7:0] rdata;
		logic rvalid;
		logic cas;
		logic [7:0] vec;
		logic vvalid;
	} cic_top_state_type;

endpackage : cic_pkg

// file: design/cic_prio.sv
/*
 Rotating priority resolver for eight channels.
 Assumes lowest names the channel of least priority; the next one up wins.
*/
`timescale 1ns/1ps

module cic_prio (
	input wire logic [7:0] req,
	input wire logic [7:0] block,
	input wire logic [2:0] lowest,
	output logic found,
	output logic [2:0] chan
);
	import cic_pkg::*;

	always_comb begin
		logic stop;
		logic [2:0] c;
		stop = 1'b0;
		c = 3'h0;
		found = 1'b0;
		chan = 3'h0;
		// Walk from highest to lowest rank; an in-service level stops it
		for (int i = 0; i < 8; i++) begin
			c = lowest + 3'(i + 1);
			if (!stop) begin
				if (block[c]) begin
					stop = 1'b1;
				end else if (req[c]) begin
					found = 1'b1;
					chan = c;
					stop = 1'b1;
				end
			end
		end
	end

endmodule : cic_prio

// file: design/cic_top.sv
/*
 Primary and secondary eight-channel interrupt controllers, cascaded,
 with their even/odd I/O ports and acknowledge handling.
 Assumes one-cycle io strobes and acknowledge pulses on clk; irq pins are
 asynchronous; timer0_output comes from logic on clk.
*/
// Operation
// - Specific rotation makes named channel lowest, next one highest.
// - Auto rotation makes just-serviced channel lowest priority.
// - With auto rotation on, every end-of-service rotates, automatic or commanded.
// - Auto rotation serves every requester within eight presented requests.
// - Even-port write with bit 4 set is init word one.
// - Init word one resets counter, priority, mask, slave id, special mask, select.
// - Next three odd-port writes are init words two, three, four.
// - Even-port write with bit 4 clear ends init, stored as command.
// - Odd-port write outside init loads the channel mask.
// - Even-port command: bit 3 clear word two, set word three.
// - Secondary behaves the same at ports A0h and A1h.
// - After poll bit, next even-port read returns the poll vector.
// - First read of the controller clears the pending poll.
// - After init word one or reset, status reads give request register.
// - Primary channel zero is driven by timer0_output.
// - Second acknowledge vector: five base bits, channel in low three.
// - First acknowledge sets in-service bit of winner; in edge mode also clears its request bit.
// - In-service channel inhibits equal and lower priority requests.
// - Nonspecific end-of-service clears highest in-service bit; specific named bit.
`timescale 1ns/1ps
`include "cic_cfg.svh"

module cic_ctrl (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wr_even,
	input wire logic wr_odd,
	input wire logic rd_even,
	input wire logic rd_any,
	input wire logic [7:0] wdata,
	input wire logic [7:0] req,
	input wire logic ack1,
	input wire logic ack2,
	output logic intr,
	output logic grant_found,
	output logic [2:0] grant_ch,
	output logic [7:0] vector,
	output logic [7:0] even_data,
	output logic [7:0] odd_data,
	output logic [2:0] slave_id
);
	import cic_pkg::*;

	cic_ctrl_state_type s_q;
	cic_ctrl_state_type s_d;
	logic [7:0] pend;
	logic [7:0] isr_eff;
	logic hi_found;
	logic [2:0] hi_ch;
	logic take;
	cic_operational_word_two_type cmd;

	// Special mask mode lets masked in-service levels stop inhibiting
	assign isr_eff = s_q.smm ? (s_q.in_service_register & ~s_q.mask_register) : s_q.in_service_register;
	assign pend = s_q.request_register & ~s_q.mask_register;
	assign cmd = cic_operational_word_two_type'(wdata[7:5]);

	cic_prio u_grant (
		.req(pend),
		.block(isr_eff),
		.lowest(s_q.lowest),
		.found(grant_found),
		.chan(grant_ch)
	);

	cic_prio u_high (
		.req(isr_eff),
		.block(8'h00),
		.lowest(s_q.lowest),
		.found(hi_found),
		.chan(hi_ch)
	);

	assign intr = grant_found;
	assign take = ack1 | (rd_even & s_q.poll_pend);
	assign vector = {s_q.vec_base, s_q.cur};
	assign slave_id = s_q.slave_id;
	assign odd_data = s_q.mask_register;

	always_comb begin
		if (s_q.poll_pend) begin
			even_data = {grant_found, 4'h0, grant_ch};
		end else if (s_q.sel_isr) begin
			even_data = s_q.in_service_register;
		end else begin
			even_data = s_q.request_register;
		end
	end

	always_comb begin
		logic [7:0] irr_base;
		irr_base = s_q.request_register;
		s_d = s_q;
		s_d.req_prev = req;

		// First acknowledge or poll read: winner moves into service
		if (take) begin
			if (grant_found) begin
				s_d.in_service_register[grant_ch] = 1'b1;
				irr_base[grant_ch] = 1'b0;
				s_d.cur = grant_ch;
			end else begin
				s_d.cur = `CIC_SPURIOUS_CH;
			end
		end

		// New edges are applied after the acknowledge clear, so none is lost
		if (s_q.level_mode) begin
			s_d.request_register = req;
		end else begin
			s_d.request_register = irr_base | (req & ~s_q.req_prev);
		end

		// Automatic end-of-service at the close of the second acknowledge
		if (ack2 && s_q.aeoi) begin
			s_d.in_service_register[s_q.cur] = 1'b0;
			if (s_q.rot_auto) begin
				s_d.lowest = s_q.cur;
			end
		end

		if (wr_even && wdata[`CIC_INIT_BIT]) begin
			s_d.phase = CIC_W2;
			s_d.level_mode = wdata[`CIC_LEVEL_BIT];
			s_d.rot_auto = 1'b0;
			s_d.lowest = `CIC_LOWEST_RST;
			s_d.mask_register = `CIC_MASK_RST;
			s_d.slave_id = `CIC_SLAVE_ID_RST;
			s_d.smm = 1'b0;
			s_d.sel_isr = 1'b0;
			s_d.poll_pend = 1'b0;
			s_d.aeoi = 1'b0;
		end else if (wr_even) begin
			s_d.phase = CIC_RUN;
			if (wdata[`CIC_OPERATIONAL_WORD_THREE_BIT]) begin
				if (wdata[`CIC_ESMM_BIT]) begin
					s_d.smm = wdata[`CIC_SMM_BIT];
				end
				if (wdata[`CIC_POLL_BIT]) begin
					s_d.poll_pend = 1'b1;
				end
				s_d.sel_isr = wdata[`CIC_RR_BIT] & ~wdata[`CIC_RIS_BIT];
			end else begin
				unique case (cmd)
					CIC_ROT_CLR: begin
						s_d.rot_auto = 1'b0;
					end
					CIC_ROT_SET: begin
						s_d.rot_auto = 1'b1;
					end
					CIC_EOI_NS, CIC_ROT_EOI_NS: begin
						if (hi_found) begin
							s_d.in_service_register[hi_ch] = 1'b0;
							if (s_q.rot_auto || cmd == CIC_ROT_EOI_NS) begin
								s_d.lowest = hi_ch;
							end
						end
					end
					CIC_EOI_SP, CIC_ROT_EOI_SP: begin
						s_d.in_service_register[wdata[2:0]] = 1'b0;
						if (s_q.rot_auto || cmd == CIC_ROT_EOI_SP) begin
							s_d.lowest = wdata[2:0];
						end
					end
					CIC_SET_PRIO: begin
						s_d.lowest = wdata[2:0];
					end
					CIC_NOP: begin
					end
				endcase
			end
		end

		if (wr_odd) begin
			unique case (s_q.phase)
				CIC_W2: begin
					s_d.vec_base = wdata[7:3];
					s_d.phase = CIC_W3;
				end
				CIC_W3: begin
					s_d.slave_id = wdata[2:0];
					s_d.phase = CIC_W4;
				end
				CIC_W4: begin
					s_d.aeoi = wdata[`CIC_AEOI_BIT];
					s_d.phase = CIC_RUN;
				end
				CIC_RUN: begin
					s_d.mask_register = wdata;
				end
			endcase
		end

		// Any read ends a pending poll, even one of the odd port
		if (rd_any) begin
			s_d.poll_pend = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.phase <= CIC_RUN;
			s_q.lowest <= `CIC_LOWEST_RST;
			s_q.slave_id <= `CIC_SLAVE_ID_RST;
			s_q.mask_register <= `CIC_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : cic_ctrl

module cic_top (
	input wire logic clk,
	input wire logic resetn,
	input cic_pkg::cic_io_req_type io_req,
	output logic [7:0] io_rdata,
	output logic io_rdata_valid,
	input wire logic [15:0] irq_pins,
	input wire logic timer0_output,
	input wire logic ack_first,
	input wire logic ack_second,
	output logic intr,
	output logic [7:0] ack_vector,
	output logic ack_vector_valid
);
	import cic_pkg::*;

	cic_top_state_type s_q;
	cic_top_state_type s_d;
	logic [7:0] pri_req;
	logic pri_found;
	logic [2:0] pri_ch;
	logic [7:0] pri_vec;
	logic [7:0] pri_even;
	logic [7:0] pri_odd;
	logic sec_intr;
	logic sec_ack1;
	logic [7:0] sec_vec;
	logic [7:0] sec_even;
	logic [7:0] sec_odd;
	logic [2:0] sec_id;
	logic pri_sel;
	logic sec_sel;

	// Channel 2 of the primary carries the secondary's request
	assign pri_req = {s_q.pin_s2[7:3], sec_intr, s_q.pin_s2[1],
		timer0_output};
	assign pri_sel = {io_req.addr[7:1], 1'b0} == `CIC_PRI_EVEN;
	assign sec_sel = {io_req.addr[7:1], 1'b0} == `CIC_SEC_EVEN;
	// Secondary answers only when the cascade code matches its slave id
	assign sec_ack1 = ack_first & pri_found & (pri_ch == `CIC_CASCADE_CH)
		& (sec_id == pri_ch);

	cic_ctrl u_pri (
		.clk(clk),
		.resetn(resetn),
		.wr_even(io_req.wr & pri_sel & ~io_req.addr[0]),
		.wr_odd(io_req.wr & pri_sel & io_req.addr[0]),
		.rd_even(io_req.rd & pri_sel & ~io_req.addr[0]),
		.rd_any(io_req.rd & pri_sel),
		.wdata(io_req.wdata),
		.req(pri_req),
		.ack1(ack_first),
		.ack2(ack_second),
		.intr(intr),
		.grant_found(pri_found),
		.grant_ch(pri_ch),
		.vector(pri_vec),
		.even_data(pri_even),
		.odd_data(pri_odd),
		.slave_id()
	);

	cic_ctrl u_sec (
		.clk(clk),
		.resetn(resetn),
		.wr_even(io_req.wr & sec_sel & ~io_req.addr[0]),
		.wr_odd(io_req.wr & sec_sel & io_req.addr[0]),
		.rd_even(io_req.rd & sec_sel & ~io_req.addr[0]),
		.rd_any(io_req.rd & sec_sel),
		.wdata(io_req.wdata),
		.req(s_q.pin_s2[15:8]),
		.ack1(sec_ack1),
		.ack2(ack_second & s_q.cas),
		.intr(sec_intr),
		.grant_found(),
		.grant_ch(),
		.vector(sec_vec),
		.even_data(sec_even),
		.odd_data(sec_odd),
		.slave_id(sec_id)
	);

	assign io_rdata = s_q.rdata;
	assign io_rdata_valid = s_q.rvalid;
	assign ack_vector = s_q.vec;
	assign ack_vector_valid = s_q.vvalid;

	always_comb begin
		s_d = s_q;
		s_d.pin_s1 = irq_pins;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.rvalid = io_req.rd;
		s_d.vvalid = ack_second;
		if (ack_first) begin
			s_d.cas = sec_ack1;
		end
		if (ack_second) begin
			s_d.vec = s_q.cas ? sec_vec : pri_vec;
		end
		if (io_req.rd) begin
			unique case (io_req.addr)
				`CIC_PRI_EVEN: s_d.rdata = pri_even;
				`CIC_PRI_ODD: s_d.rdata = pri_odd;
				`CIC_SEC_EVEN: s_d.rdata = sec_even;
				`CIC_SEC_ODD: s_d.rdata = sec_odd;
				default: s_d.rdata = `CIC_UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : cic_top

// file: bench/cic_host.sv
/*
 Host model: I/O writes and reads, init sequence, acknowledge cycles.
 Assumes a cic_top on the same clk.
*/
`timescale 1ns/1ps

module cic_host (
	input wire logic clk,
	input wire logic intr,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] ack_vector,
	output cic_pkg::cic_io_req_type io_req,
	output logic ack_first,
	output logic ack_second
);
	import cic_pkg::*;
	initial begin
		io_req = '0;
		ack_first = 1'b0;
		ack_second = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) io_req <= '{a, 1'b1, 1'b0, d};
		@(posedge clk) io_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) io_req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge clk) io_req.rd <= 1'b0;
		#1 d = io_rdata;
	endtask : rd
	// All four bytes always go out, never a partial sequence
	task automatic init(input logic [7:0] a, input logic [4:0] b,
		input logic [2:0] id);
		wr(a, 8'h10);
		wr(a + 8'h01, {b, 3'h0});
		wr(a + 8'h01, {5'h00, id});
		wr(a + 8'h01, 8'h00);
	endtask : init
	// Random gap between the two cycles models a slow CPU
	task automatic ack(output logic [7:0] v, output logic ok);
		int n;
		n = 0;
		while (intr !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1 n++;
		end
		ok = (intr === 1'b1);
		@(posedge clk) ack_first <= 1'b1;
		@(posedge clk) ack_first <= 1'b0;
		repeat ($urandom_range(2, 0)) @(posedge clk);
		@(posedge clk) ack_second <= 1'b1;
		@(posedge clk) ack_second <= 1'b0;
		#1 v = ack_vector;
	endtask : ack
endmodule : cic_host

// file: bench/cic_top_assertions.sv
/*
 Port checker for cic_top, bound below.
 Assumes one-cycle strobes with an idle cycle between host requests.
*/
`timescale 1ns/1ps

module cic_top_assertions (
	input wire logic clk,
	input wire logic resetn,
	input cic_pkg::cic_io_req_type io_req,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	input wire logic ack_first,
	input wire logic ack_second,
	input wire logic [7:0] ack_vector,
	input wire logic ack_vector_valid
);
	import cic_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_wr(logic [7:0] a);
		io_req.wr && io_req.addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		io_req.rd && io_req.addr == a;
	endsequence
	sequence s_cmd;
		s_wr(8'h20) ##0 !io_req.wdata[4];
	endsequence
	property p_rd_valid;
		io_req.rd |=> io_rdata_valid;
	endproperty
	a_rd_valid: assert property (p_rd_valid)
		else $error("read not answered");
	property p_no_rd;
		!io_req.rd |=> !io_rdata_valid;
	endproperty
	a_no_rd: assert property (p_no_rd)
		else $error("stray read valid");
	property p_vec_valid;
		ack_second |=> ack_vector_valid;
	endproperty
	a_vec_valid: assert property (p_vec_valid)
		else $error("vector not given");
	property p_no_vec;
		!ack_second |=> !ack_vector_valid;
	endproperty
	a_no_vec: assert property (p_no_vec)
		else $error("stray vector valid");
	property p_unmapped;
		io_req.rd && !(io_req.addr inside {8'h20, 8'h21, 8'hA0, 8'hA1})
			|=> io_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_init_mask;
		(s_wr(8'h20) ##0 io_req.wdata[4]) ##[1:2] s_rd(8'h21)
			|=> io_rdata == 8'h00;
	endproperty
	a_init_mask: assert property (p_init_mask)
		else $error("mask not cleared by init");
	property p_mask;
		logic [7:0] v;
		(s_cmd ##[1:2] (s_wr(8'h21), v = io_req.wdata) ##[1:2] s_rd(8'h21))
			|=> io_rdata == v;
	endproperty
	a_mask: assert property (p_mask)
		else $error("mask readback wrong");
	property p_poll;
		(s_cmd ##0 io_req.wdata[3:2] == 2'b11) ##[1:2] s_rd(8'h20)
			|=> io_rdata[6:3] == 4'h0;
	endproperty
	a_poll: assert property (p_poll)
		else $error("poll byte malformed");
endmodule : cic_top_assertions

bind cic_top cic_top_assertions u_cic_top_assertions (.clk, .resetn,
	.io_req, .io_rdata, .io_rdata_valid, .ack_first, .ack_second,
	.ack_vector, .ack_vector_valid);

// file: bench/cic_top_test.sv
/*
 Self-checking bench for cic_top with the cic_host model.
 Assumes the design files are compiled first.
*/
`timescale 1ns/1ps

module cic_top_test;
	import cic_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] irq_pins = 16'h0000;
	logic timer0_output = 1'b0;
	cic_io_req_type io_req;
	logic [7:0] io_rdata, ack_vector, d, a, m;
	logic io_rdata_valid, ack_first, ack_second, intr, ack_vector_valid, ok;
	logic [4:0] base;
	logic [2:0] order [4] = '{3'h6, 3'h0, 3'h3, 3'h4};
	int error_cnt = 0;
	int checks = 0;
	always #50 clk = ~clk;
	cic_top u_cic_top (.clk, .resetn, .io_req, .io_rdata, .io_rdata_valid,
		.irq_pins, .timer0_output, .ack_first, .ack_second, .intr,
		.ack_vector, .ack_vector_valid);
	cic_host u_cic_host (.clk, .intr, .io_rdata, .ack_vector, .io_req,
		.ack_first, .ack_second);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	function automatic logic [7:0] vec(input logic [2:0] ch);
		return {base, ch};
	endfunction : vec
	task automatic take(input logic [2:0] ch);
		u_cic_host.ack(d, ok);
		check({7'h00, ok}, 8'h01);
		if (ok !== 1'b1) begin
			test_done();
		end
		check(d, vec(ch));
	endtask : take
	initial begin
		void'($urandom(2323));
		base = 5'($urandom);
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		u_cic_host.rd(8'h20, d);
		check(d, 8'h00);
		u_cic_host.rd(8'h22, d);
		check(d, 8'h00);
		for (int i = 0; i < 2; i++) begin
			a = i ? 8'hA0 : 8'h20;
			u_cic_host.wr(a + 8'h01, 8'h5A);
			u_cic_host.init(a, base, i ? 3'h2 : 3'h4);
			u_cic_host.rd(a + 8'h01, d);
			check(d, 8'h00);
			m = 8'($urandom);
			u_cic_host.wr(a + 8'h01, m);
			u_cic_host.rd(a + 8'h01, d);
			check(d, m);
		end
		// Aborted init: only word two written, then a command
		u_cic_host.wr(8'h20, 8'h10);
		u_cic_host.rd(8'h21, d);
		check(d, 8'h00);
		u_cic_host.wr(8'h21, {base, 3'h0});
		u_cic_host.wr(8'h20, 8'h08);
		u_cic_host.wr(8'h21, 8'hF0);
		u_cic_host.rd(8'h21, d);
		check(d, 8'hF0);
		u_cic_host.wr(8'h21, 8'h00);
		$display("test init done");
		@(posedge clk) irq_pins <= 16'h0008;
		repeat (5) @(posedge clk);
		u_cic_host.rd(8'h20, d);
		check(d, 8'h08);
		take(3'h3);
		u_cic_host.wr(8'h20, 8'h0A);
		u_cic_host.rd(8'h20, d);
		check(d, 8'h08);
		u_cic_host.wr(8'h20, 8'h0B);
		u_cic_host.rd(8'h20, d);
		check(d, 8'h00);
		u_cic_host.wr(8'h20, 8'h20);
		u_cic_host.wr(8'h20, 8'h0A);
		u_cic_host.rd(8'h20, d);
		check(d, 8'h00);
		$display("test ack done");
		@(posedge clk) irq_pins <= 16'h0000;
		repeat (4) @(posedge clk);
		irq_pins <= 16'h0018;
		repeat (5) @(posedge clk);
		u_cic_host.wr(8'h20, 8'h0C);
		u_cic_host.rd(8'h20, d);
		check(d, 8'h83);
		u_cic_host.rd(8'h20, d);
		check(d, 8'h10);
		u_cic_host.wr(8'h20, 8'h20);
		$display("test poll done");
		// Channel 5 lowest puts 6 first, then timer channel 0
		u_cic_host.wr(8'h20, 8'hC5);
		@(posedge clk) irq_pins <= 16'h0000;
		repeat (4) @(posedge clk);
		irq_pins <= 16'h0048;
		timer0_output <= 1'b1;
		// Let the pin edges pass the synchroniser before the first grant
		repeat (5) @(posedge clk);
		foreach (order[k]) begin
			take(order[k]);
			u_cic_host.wr(8'h20, {5'h0C, order[k]});
		end
		$display("test rotate done");
		// Secondary channel 1 answers through primary channel 2
		u_cic_host.wr(8'hA1, 8'h00);
		irq_pins <= 16'h0248;
		take(3'h1);
		u_cic_host.wr(8'hA0, 8'h61);
		u_cic_host.wr(8'h20, 8'h62);
		$display("test cascade done");
		// Auto rotation: a serviced channel drops below a waiting one
		u_cic_host.wr(8'h20, 8'h80);
		irq_pins <= 16'h0000;
		repeat (4) @(posedge clk);
		irq_pins <= 16'h0050;
		take(3'h6);
		u_cic_host.wr(8'h20, 8'h20);
		irq_pins <= 16'h0000;
		repeat (4) @(posedge clk);
		irq_pins <= 16'h0040;
		repeat (4) @(posedge clk);
		take(3'h4);
		u_cic_host.wr(8'h20, 8'h20);
		take(3'h6);
		u_cic_host.wr(8'h20, 8'h20);
		u_cic_host.wr(8'h20, 8'h00);
		$display("test auto rotate done");
		// Masked request is latched but not presented until unmasked
		u_cic_host.wr(8'h21, 8'h20);
		irq_pins <= 16'h0060;
		repeat (5) @(posedge clk);
		u_cic_host.rd(8'h20, d);
		check(d, 8'h20);
		u_cic_host.ack(d, ok);
		check({7'h00, ok}, 8'h00);
		check(d, vec(3'h7));
		u_cic_host.wr(8'h21, 8'h00);
		take(3'h5);
		u_cic_host.wr(8'h20, 8'h20);
		$display("test mask done");
		test_done();
	end
endmodule : cic_top_test
